// ==== rtl/status_bank_defs.svh ====
// Purpose: Constants of the serial memory status register bank
// Assumes: Included by the package and the top module
// Notes: Bit positions, opcodes, reset values and sync depth
//
// Notes on behaviour
// [R1] Quad mode flag bit 6, volatile, zero
// [R2] Quad enter command sets quad flag
// [R3] Quad exit command clears quad flag
// [R4] Status write never changes quad flag
// [R5] Latency select bits 5:4 are nonvolatile
// [R6] Status write updates latency, protect fields
// [R7] Protect size bits 3:2 are nonvolatile
// [R8] Write latch bit 1, volatile, zero
// [R9] Latch set command sets write latch
// [R10] Latch clear command clears write latch
// [R11] Status write cannot change write latch
// [R12] Status write end clears write latch
// [R13] Quad write ends clear write latch
// [R14] Single array write end clears latch
// [R15] Protect enable bit 7 nonvolatile, gates writes
// [R16] Bit 0 reads zero, writes ignored
`ifndef STATUS_BANK_DEFS_SVH
`define STATUS_BANK_DEFS_SVH

// Status bit positions
`define PROT_EN_BIT 7
`define QUAD_BIT 6
`define LAT_HI_BIT 5
`define LAT_LO_BIT 4
`define PROT_HI_BIT 3
`define PROT_LO_BIT 2
`define LATCH_BIT 1
`define ZERO_BIT 0

// Bits a status write may change
`define NV_WRITE_MASK 8'hBC
// Default power-up contents of the nonvolatile bits
`define NV_RESET 8'h00

// Command opcodes
`define OP_LATCH_SET 8'h06
`define OP_LATCH_CLEAR 8'h04
`define OP_STATUS_READ 8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_ARRAY_WRITE 8'h02
`define OP_QUAD_DATA_WRITE 8'h32
`define OP_QUAD_ADDR_DATA_WRITE 8'h12
`define OP_QUAD_ENTER 8'h38
`define OP_QUAD_EXIT 8'hFF

// Synchroniser depth and index of the last bit of a byte
`define SYNC_STAGES 3
`define BITS_PER_BYTE 3'h7

`endif

// ==== rtl/status_bank_pkg.sv ====
// Purpose: Types shared by the status register bank
// Assumes: status_bank_defs.svh holds the numbers
// Notes: Command decode is used in both clock domains
`include "status_bank_defs.svh"

package status_bank_pkg;

  // Decoded command classes
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_LATCH_SET = 4'h1,
    CMD_LATCH_CLEAR = 4'h2,
    CMD_STATUS_READ = 4'h3,
    CMD_STATUS_WRITE = 4'h4,
    CMD_ARRAY_WRITE = 4'h5,
    CMD_QUAD_ENTER = 4'h6,
    CMD_QUAD_EXIT = 4'h7
  } cmd_t;

  // Nonvolatile part of the status word
  typedef struct packed {
    logic prot_en;
    logic [1:0] latency_sel;
    logic [1:0] protect_size;
  } nv_bits_t;

  // Opcode to command class
  function automatic cmd_t decode_cmd(input logic [7:0] op);
    cmd_t c;
    c = CMD_NONE;
    case (op)
      `OP_LATCH_SET: c = CMD_LATCH_SET;
      `OP_LATCH_CLEAR: c = CMD_LATCH_CLEAR;
      `OP_STATUS_READ: c = CMD_STATUS_READ;
      `OP_STATUS_WRITE: c = CMD_STATUS_WRITE;
      `OP_ARRAY_WRITE: c = CMD_ARRAY_WRITE;
      `OP_QUAD_DATA_WRITE: c = CMD_ARRAY_WRITE;
      `OP_QUAD_ADDR_DATA_WRITE: c = CMD_ARRAY_WRITE;
      `OP_QUAD_ENTER: c = CMD_QUAD_ENTER;
      `OP_QUAD_EXIT: c = CMD_QUAD_EXIT;
      default: c = CMD_NONE;
    endcase
    return c;
  endfunction : decode_cmd

endpackage : status_bank_pkg

// ==== rtl/level_sync.sv ====
// Purpose: Three-stage synchroniser for a group of levels
// Assumes: Inputs come from another clock or a pin
// Notes: Output moves only when stages two and three agree
`timescale 1ns/1ps

module level_sync
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // Stage registers
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  // Refuse an empty group
  if (WIDTH < 1)
  begin : g_chk
    $error("level_sync width must be at least one");
  end

  // Shift chain, first stage read only by the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accept a bit once the last two stages agree
  genvar i;
  for (i = 0; i < WIDTH; i++)
  begin : g_agree
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        q[i] <= RESET_VAL[i];
      end
      else if (s2_r[i] == s3_r[i])
      begin
        q[i] <= s3_r[i];
      end
    end
  end

endmodule : level_sync

// ==== rtl/serial_status_bank.sv ====
// Purpose: Status register of a serial memory target
// Assumes: Single-line link, clock mode 0, SCK runs only in frames
// Notes: Link side on SCK, register state on SYS_CLK
`timescale 1ns/1ps
`include "status_bank_defs.svh"

module serial_status_bank
#(
  parameter logic [7:0] NV_INIT = `NV_RESET
)
(
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SI,
  input wire logic WP_N,
  output logic SO_OUT,
  output logic SO_OE,
  output logic QUAD_MODE,
  output logic WRITE_LATCH,
  output logic [1:0] LATENCY_SEL,
  output logic [1:0] PROTECT_SIZE
);
  import status_bank_pkg::*;

  // Power-up contents may only touch nonvolatile bits
  if ((NV_INIT & ~`NV_WRITE_MASK) != 8'h00)
  begin : g_chk
    $error("NV_INIT sets bits outside the nonvolatile field");
  end

  ////////////////////////////////////////////////////////////////////////
  // Link domain: frame decode on SCK
  ////////////////////////////////////////////////////////////////////////

  // Frame logic rests whenever chip select is high
  logic frame_rst_n;
  // Bit position within a byte
  logic [2:0] bit_cnt_r;
  // Whole bytes seen in this frame, saturating
  logic [1:0] byte_idx_r;
  // Incoming shift register
  logic [7:0] rx_r;
  // Last opcode and last data byte, held across frames
  logic [7:0] opcode_r;
  logic [7:0] wdat_r;
  // Event toggles toward the register domain
  logic op_tgl_r;
  logic dat_tgl_r;
  // Status word seen on the link clock
  logic [7:0] stat_link;
  // Outgoing shift register
  logic [7:0] tx_r;
  // Command class of the held opcode on the link side
  cmd_t link_cmd;

  assign frame_rst_n = NRST & ~CS_N;
  assign link_cmd = decode_cmd(opcode_r);

  // Bit and byte counting, restarted by each frame
  always_ff @(posedge SCK or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      bit_cnt_r <= 3'h0;
      byte_idx_r <= 2'h0;
    end
    else
    begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      // Count bytes up to two
      if (bit_cnt_r == `BITS_PER_BYTE && byte_idx_r != 2'h2)
      begin
        byte_idx_r <= byte_idx_r + 2'h1;
      end
    end
  end

  // Sample the data line on the rising edge
  always_ff @(posedge SCK or negedge NRST)
  begin
    if (!NRST)
    begin
      rx_r <= 8'h00;
    end
    else
    begin
      rx_r <= {rx_r[6:0], SI};
    end
  end

  // Opcode capture; a partial opcode never completes
  always_ff @(posedge SCK or negedge NRST)
  begin
    if (!NRST)
    begin
      opcode_r <= 8'h00;
      op_tgl_r <= 1'b0;
    end
    else if (!CS_N && bit_cnt_r == `BITS_PER_BYTE && byte_idx_r == 2'h0)
    begin
      opcode_r <= {rx_r[6:0], SI};
      op_tgl_r <= ~op_tgl_r;
    end
  end

  // Second byte capture, the status write payload
  always_ff @(posedge SCK or negedge NRST)
  begin
    if (!NRST)
    begin
      wdat_r <= 8'h00;
      dat_tgl_r <= 1'b0;
    end
    else if (!CS_N && bit_cnt_r == `BITS_PER_BYTE && byte_idx_r == 2'h1)
    begin
      wdat_r <= {rx_r[6:0], SI};
      dat_tgl_r <= ~dat_tgl_r;
    end
  end

  // Drive status bytes out on the falling edge, repeated per byte
  always_ff @(negedge SCK or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      SO_OUT <= 1'b0;
      SO_OE <= 1'b0;
      tx_r <= 8'h00;
    end
    else if (bit_cnt_r == 3'h0 && byte_idx_r != 2'h0 &&
             link_cmd == CMD_STATUS_READ)
    begin
      // Reload at each byte boundary after the opcode
      SO_OUT <= stat_link[7];
      tx_r <= {stat_link[6:0], 1'b0};
      SO_OE <= 1'b1;
    end
    else if (SO_OE)
    begin
      // Shift the current byte out MSB first
      SO_OUT <= tx_r[7];
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Crossings
  ////////////////////////////////////////////////////////////////////////

  // Status word handed to the link
  logic [7:0] stat_word_r;
  // Synchronised chip select, protect pin and toggles
  logic cs_n_s;
  logic wp_n_s;
  logic op_tgl_s;
  logic dat_tgl_s;

  // Pins and link events into the register domain
  level_sync #(
    .WIDTH(4),
    .RESET_VAL(4'b1100)
  ) u_sys_sync (
    .clk(SYS_CLK),
    .rst_n(NRST),
    .d({CS_N, WP_N, op_tgl_r, dat_tgl_r}),
    .q({cs_n_s, wp_n_s, op_tgl_s, dat_tgl_s})
  );

  // Quasi-static status word onto the link clock
  level_sync #(
    .WIDTH(8),
    .RESET_VAL(8'h00)
  ) u_link_sync (
    .clk(SCK),
    .rst_n(NRST),
    .d(stat_word_r),
    .q(stat_link)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register domain: event detection on SYS_CLK
  ////////////////////////////////////////////////////////////////////////

  // Edge history of the synchronised signals
  logic cs_n_prev_r;
  logic op_seen_r;
  logic dat_seen_r;
  // One-cycle events
  logic cs_rise;
  logic op_evt;
  logic dat_evt;
  // Command class of the opcode just received
  cmd_t evt_cmd;

  assign cs_rise = cs_n_s & ~cs_n_prev_r;
  assign op_evt = op_tgl_s ^ op_seen_r;
  assign dat_evt = dat_tgl_s ^ dat_seen_r;
  // Opcode is stable: it changes only a byte after its toggle
  assign evt_cmd = op_evt ? decode_cmd(opcode_r) : CMD_NONE;

  // Track the synchronised levels
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      cs_n_prev_r <= 1'b1;
      op_seen_r <= 1'b0;
      dat_seen_r <= 1'b0;
    end
    else
    begin
      cs_n_prev_r <= cs_n_s;
      op_seen_r <= op_tgl_s;
      dat_seen_r <= dat_tgl_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame bookkeeping until chip select rises
  ////////////////////////////////////////////////////////////////////////

  // Recognised status write in the open frame
  logic pend_sw_r;
  // Recognised array write in the open frame
  logic pend_aw_r;
  // Payload byte arrived for the status write
  logic have_dat_r;
  // Copy of the payload byte
  logic [7:0] wdat_hold_r;

  // Remember what the frame asked for
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      pend_sw_r <= 1'b0;
      pend_aw_r <= 1'b0;
    end
    else if (cs_rise)
    begin
      // Frame over, forget it
      pend_sw_r <= 1'b0;
      pend_aw_r <= 1'b0;
    end
    else if (op_evt)
    begin
      pend_sw_r <= (evt_cmd == CMD_STATUS_WRITE);
      pend_aw_r <= (evt_cmd == CMD_ARRAY_WRITE);
    end
  end

  // Catch the payload byte
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      have_dat_r <= 1'b0;
      wdat_hold_r <= 8'h00;
    end
    else if (cs_rise || op_evt)
    begin
      have_dat_r <= 1'b0;
    end
    else if (dat_evt && pend_sw_r)
    begin
      have_dat_r <= 1'b1;
      wdat_hold_r <= wdat_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status bits
  ////////////////////////////////////////////////////////////////////////

  // Nonvolatile bits, loaded from NV_INIT at power-up
  nv_bits_t nv_r;
  // Volatile quad flag and write latch
  logic quad_r;
  logic latch_r;
  // Status write permitted by latch and protect pin
  logic sw_allowed;
  // Latch clear at the end of a recognised write frame
  logic end_clear;

  assign sw_allowed = latch_r & ~(nv_r.prot_en & ~wp_n_s); // see [R15]
  assign end_clear = cs_rise & (pend_sw_r | pend_aw_r); // see [R12]

  // Nonvolatile fields change only by a permitted status write
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      nv_r.prot_en <= NV_INIT[`PROT_EN_BIT]; // see [R15]
      nv_r.latency_sel <= NV_INIT[`LAT_HI_BIT:`LAT_LO_BIT]; // see [R5]
      nv_r.protect_size <= NV_INIT[`PROT_HI_BIT:`PROT_LO_BIT]; // see [R7]
    end
    else if (cs_rise && pend_sw_r && have_dat_r && sw_allowed)
    begin
      // Bits 6, 1 and 0 of the payload are dropped
      nv_r.prot_en <= wdat_hold_r[`PROT_EN_BIT]; // see [R15]
      nv_r.latency_sel <= wdat_hold_r[`LAT_HI_BIT:`LAT_LO_BIT]; // see [R6]
      nv_r.protect_size <=
        wdat_hold_r[`PROT_HI_BIT:`PROT_LO_BIT]; // see [R6]
    end
  end

  // Quad flag follows only the enter and exit commands
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      quad_r <= 1'b0; // see [R1]
    end
    else if (evt_cmd == CMD_QUAD_ENTER)
    begin
      quad_r <= 1'b1; // see [R2]
    end
    else if (evt_cmd == CMD_QUAD_EXIT)
    begin
      quad_r <= 1'b0; // see [R3]
    end
  end

  // Write latch: set command wins over any clear
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      latch_r <= 1'b0; // see [R8]
    end
    else if (evt_cmd == CMD_LATCH_SET)
    begin
      latch_r <= 1'b1; // see [R9]
    end
    else if (evt_cmd == CMD_LATCH_CLEAR)
    begin
      latch_r <= 1'b0; // see [R10]
    end
    else if (end_clear)
    begin
      // Status, single and quad writes all clear it
      latch_r <= 1'b0; // see [R13] see [R14]
    end
  end

  // Readable image; quad and latch never come from the payload
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      stat_word_r <= 8'h00;
    end
    else
    begin
      stat_word_r[`PROT_EN_BIT] <= nv_r.prot_en;
      stat_word_r[`QUAD_BIT] <= quad_r; // see [R4]
      stat_word_r[`LAT_HI_BIT:`LAT_LO_BIT] <= nv_r.latency_sel;
      stat_word_r[`PROT_HI_BIT:`PROT_LO_BIT] <= nv_r.protect_size;
      stat_word_r[`LATCH_BIT] <= latch_r; // see [R11]
      stat_word_r[`ZERO_BIT] <= 1'b0; // see [R16]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs toward the rest of the memory
  ////////////////////////////////////////////////////////////////////////

  // Registered copies of the fields the array logic uses
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      QUAD_MODE <= 1'b0;
      WRITE_LATCH <= 1'b0;
      LATENCY_SEL <= 2'h0;
      PROTECT_SIZE <= 2'h0;
    end
    else
    begin
      QUAD_MODE <= quad_r;
      WRITE_LATCH <= latch_r;
      LATENCY_SEL <= nv_r.latency_sel; // see [R5]
      PROTECT_SIZE <= nv_r.protect_size; // see [R7]
    end
  end

endmodule : serial_status_bank

// ==== dv/serial_status_bank_asserts.sv ====
// Purpose: Port assertions for the status register bank
// Assumes: Bound to serial_status_bank, SCK and CS_N seen on SYS_CLK
// Notes: Field changes must sit close to frame activity
`timescale 1ns/1ps

module serial_status_bank_asserts
(
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SI,
  input wire logic WP_N,
  input wire logic SO_OUT,
  input wire logic SO_OE,
  input wire logic QUAD_MODE,
  input wire logic WRITE_LATCH,
  input wire logic [1:0] LATENCY_SEL,
  input wire logic [1:0] PROTECT_SIZE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  // Cycles since CS_N went high, saturating
  logic [4:0] idle_r;
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
      idle_r <= 5'h1f;
    else if (!CS_N)
      idle_r <= 5'h00;
    else if (idle_r != 5'h1f)
      idle_r <= idle_r + 5'h01;
  end
  ////////////////////////////////////////////////////////////////////////
  chk_vol_reset: assert property (
    $rose(NRST) |-> !QUAD_MODE && !WRITE_LATCH)
    else $error("Volatile bits set after reset");
  chk_quad_move: assert property (
    $changed(QUAD_MODE) |-> idle_r < 5'h0c)
    else $error("Quad flag moved away from a frame");
  chk_latch_set: assert property (
    $rose(WRITE_LATCH) |-> !CS_N || idle_r < 5'h0c)
    else $error("Write latch rose away from a frame");
  chk_latch_drop: assert property (
    $fell(WRITE_LATCH) |-> !CS_N || idle_r < 5'h0c)
    else $error("Write latch fell away from a frame");
  chk_lat_update: assert property (
    $changed(LATENCY_SEL) |-> CS_N && idle_r < 5'h0c)
    else $error("Latency field moved outside a frame end");
  chk_prot_update: assert property (
    $changed(PROTECT_SIZE) |-> CS_N && idle_r < 5'h0c)
    else $error("Protect field moved outside a frame end");
  chk_oe_frame: assert property (
    SO_OE |-> !CS_N)
    else $error("SO driven while deselected");
  chk_oe_launch: assert property (
    $rose(SO_OE) |-> !SCK && !CS_N)
    else $error("SO enabled off the falling edge");
  chk_so_hold: assert property (
    SO_OE && SCK && $past(SCK) |-> $stable(SO_OUT))
    else $error("SO moved while SCK high");
  // Main scenarios reached
  cover property ($rose(SO_OE));
  cover property ($changed(LATENCY_SEL));
  cover property ($rose(QUAD_MODE));
  cover property ($fell(WRITE_LATCH) && CS_N);
endmodule : serial_status_bank_asserts

// ==== dv/spi_host_model.sv ====
// Purpose: Host controller model on the serial link
// Assumes: Clock mode 0, SCK period 80 ns, SCK still between frames
// Notes: Released SO shows the inverse of its last driven level
`timescale 1ns/1ps

module spi_host_model
(
  output logic sck,
  output logic cs_n,
  output logic si,
  input wire logic so_out,
  input wire logic so_oe
);
  logic so_last;
  logic so_wire;
  // SO level as the host sees it
  assign so_wire = so_oe ? so_out : ~so_last;
  always @(so_out or so_oe)
    if (so_oe)
      so_last = so_out;
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    so_last = 1'b0;
  end
  // Shift n bits of d MSB first; capture the second byte from SO
  task automatic frame(input logic [31:0] d, input int n,
                       output logic [7:0] rd);
    int i;
    rd = 8'h00;
    // Step off the system clock edges; the link keeps its own phase
    #13.1;
    cs_n = 1'b0;
    #40;
    for (i = 0; i < n; i++)
    begin
      si = d[31-i];
      #40 sck = 1'b1;
      if (i >= 8 && i < 16)
        rd = {rd[6:0], so_wire};
      #40 sck = 1'b0;
    end
    #20 si = ~si;
    #20 cs_n = 1'b1;
    #120;
  endtask : frame
endmodule : spi_host_model

// ==== dv/test_serial_status_bank.sv ====
// Purpose: Self-checking bench for the status register bank
// Assumes: Host model drives the link, bench drives reset and WP_N
// Notes: Model of the status byte kept in plain variables
`timescale 1ns/1ps
`include "status_bank_defs.svh"

module test_serial_status_bank;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic wp_n = 1'b1;
  logic sck, cs_n, si, so_out, so_oe, quad_mode, write_latch;
  logic [1:0] latency_sel, protect_size;
  logic [7:0] port_sr, rd, nv, ops [13];
  logic quad, latch;
  int error_cnt = 0, checks = 0, seed = 32'h301d, i;
  always #2.5 sys_clk = ~sys_clk;
  assign port_sr = {1'b0, quad_mode, latency_sel, protect_size,
                    write_latch, 1'b0};
  serial_status_bank serial_status_bank_i (.SYS_CLK(sys_clk),
    .NRST(nrst), .SCK(sck), .CS_N(cs_n), .SI(si), .WP_N(wp_n),
    .SO_OUT(so_out), .SO_OE(so_oe), .QUAD_MODE(quad_mode),
    .WRITE_LATCH(write_latch), .LATENCY_SEL(latency_sel),
    .PROTECT_SIZE(protect_size));
  spi_host_model spi_host_model_i (.sck(sck), .cs_n(cs_n), .si(si),
    .so_out(so_out), .so_oe(so_oe));
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [7:0] exp_sr();
    return (nv & `NV_WRITE_MASK) | {1'b0, quad, 4'h0, latch, 1'b0};
  endfunction : exp_sr
  // Bounded wait for the outputs to reach the model
  task automatic settle();
    int k;
    // Look between edges, where the registered outputs have settled
    @(negedge sys_clk);
    for (k = 0; k < 40 && port_sr !== (exp_sr() & 8'h7e); k++)
      @(negedge sys_clk);
    check(port_sr, exp_sr() & 8'h7e);
    if (k == 40)
      complete_run();
  endtask : settle
  task automatic read_back();
    spi_host_model_i.frame({`OP_STATUS_READ, 24'h0}, 16, rd);
    check(rd, exp_sr());
  endtask : read_back
  // One command frame with random payload, then the model update
  task automatic do_op(input logic [7:0] op);
    logic [7:0] pay;
    pay = 8'($random(seed));
    @(posedge sys_clk);
    wp_n <= 1'($random(seed));
    repeat (8) @(posedge sys_clk);
    spi_host_model_i.frame({op, pay, 16'h0}, op == `OP_STATUS_WRITE ?
      16 : (op == `OP_ARRAY_WRITE || op == `OP_QUAD_DATA_WRITE ||
      op == `OP_QUAD_ADDR_DATA_WRITE) ? 32 : 8, rd);
    case (op)
      `OP_LATCH_SET: latch = 1'b1;
      `OP_LATCH_CLEAR: latch = 1'b0;
      `OP_QUAD_ENTER: quad = 1'b1;
      `OP_QUAD_EXIT: quad = 1'b0;
      `OP_STATUS_WRITE:
      begin
        if (latch && !(nv[7] && !wp_n))
          nv = pay & `NV_WRITE_MASK;
        latch = 1'b0;
      end
      default: latch = 1'b0;
    endcase
    settle();
    read_back();
  endtask : do_op
  task automatic complete_run();
    $display("Checks %0d, errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #400us;
    error_cnt++;
    complete_run();
  end
  // Main sequence: reset, every command, abort, random mix, reset again
  initial
  begin
    nv = 8'h00;
    quad = 1'b0;
    latch = 1'b0;
    ops = '{8'h06, 8'h01, 8'h38, 8'h01, 8'h06, 8'h02, 8'h06, 8'h32,
            8'h06, 8'h12, 8'h06, 8'h04, 8'hff};
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    settle();
    read_back();
    foreach (ops[j])
      do_op(ops[j]);
    spi_host_model_i.frame({`OP_LATCH_SET, 24'h0}, 4, rd);
    settle();
    for (i = 0; i < 30; i++)
      do_op(ops[{$random(seed)} % 13]);
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    nv = 8'h00;
    quad = 1'b0;
    latch = 1'b0;
    repeat (4) @(posedge sys_clk);
    settle();
    read_back();
    complete_run();
  end
endmodule : test_serial_status_bank

bind serial_status_bank serial_status_bank_asserts
  serial_status_bank_asserts_i (.SYS_CLK(SYS_CLK), .NRST(NRST),
  .SCK(SCK), .CS_N(CS_N), .SI(SI), .WP_N(WP_N), .SO_OUT(SO_OUT),
  .SO_OE(SO_OE), .QUAD_MODE(QUAD_MODE), .WRITE_LATCH(WRITE_LATCH),
  .LATENCY_SEL(LATENCY_SEL), .PROTECT_SIZE(PROTECT_SIZE));
